/* File: bench/ebi_bus_if_sva.sv */
/* Port checker of ebi_bus_if, bound at the foot of this file.
   Assumes the design's port names and one clock domain. */
`timescale 1ns/1ns
module ebi_bus_if_sva #(parameter int ADDR_LINES = 24) (
  input wire logic sys_clk, reset_n, wait_pin, rsp_valid, bus_is_16,
  input wire logic boot_external, config_done, address_latch_strobe,
  input wire logic code_fetch_strobe_n, data_read_strobe_n,
  input wire logic low_byte_write_strobe_n, high_byte_write_strobe_n,
  input wire logic [ADDR_LINES-1:0] ext_addr, ext_addr_is_bus
);
  logic used_reg;
  wire  on = !(code_fetch_strobe_n && data_read_strobe_n
    && low_byte_write_strobe_n && high_byte_write_strobe_n);
  // Set once any strobe has been driven
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n) used_reg <= 1'b0;
    else if (on) used_reg <= 1'b1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  AST_ONE_CLASS: assert property ($onehot0({!code_fetch_strobe_n,
    !data_read_strobe_n, !(low_byte_write_strobe_n
    && high_byte_write_strobe_n)})) else $error("two strobe classes");
  AST_ALE_FIRST: assert property ($rose(on)
    |-> $past(address_latch_strobe)) else $error("strobe without latch");
  AST_HIGH_16: assert property (!high_byte_write_strobe_n
    |-> bus_is_16) else $error("high lane on narrow bus");
  AST_RSP_END: assert property (rsp_valid |-> !on && $past(on))
    else $error("answer not at strobe end");
  AST_WAIT_HOLD: assert property (wait_pin [*4] ##0 on |=> on)
    else $error("cycle ended under wait");
  AST_BOOT_KEEP: assert property (config_done
    && $past(config_done) |-> $stable(boot_external))
    else $error("boot source changed");
  AST_ADDR_MASK: assert property (
    (ext_addr & ~ext_addr_is_bus) == '0) else $error("unused line driven");
  AST_WIDTH_LOCK: assert property (used_reg |-> $stable(bus_is_16))
    else $error("width changed after bus use");
  cover property (rsp_valid && !bus_is_16);
  cover property (wait_pin && on);
  cover property (!high_byte_write_strobe_n);
endmodule : ebi_bus_if_sva

bind ebi_bus_if ebi_bus_if_sva #(.ADDR_LINES(ADDR_LINES))
  u_ebi_bus_if_sva (.*);

/* File: bench/ebi_bus_if_tb_top.sv */
/* Bench of ebi_bus_if with the far-side memory model.
   Assumes package, design, model and checker compiled first. */
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  errors++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module ebi_bus_if_tb_top;
  import ebi_pkg::*;
  logic sys_clk = 0, reset_n = 0, req_valid = 0, slow = 0;
  logic fw_width_set = 0, fw_width_16 = 0;
  logic width_strap_pin = 0, external_code_select_pin = 0;
  ebi_kind_t req_kind = EBI_KIND_CODE;
  logic [23:0] req_addr = 0, ext_addr, ext_addr_is_bus;
  logic [15:0] req_wdata = 0, rsp_rdata, ext_data_in, ext_data_out;
  logic [1:0] req_byte_en = 0;
  logic [4:0] addr_lines_cfg = 5'h18;
  logic req_ready, rsp_valid, bus_is_16, boot_external, config_done;
  logic wait_pin, address_latch_strobe, code_fetch_strobe_n, ext_data_oe;
  logic data_read_strobe_n, low_byte_write_strobe_n, high_byte_write_strobe_n;
  logic [3:0] ale_w = 4'h1, code_w = 4'h4, read_w = 4'h4, write_w = 4'h4;
  logic [3:0] hold_w = 4'h2;
  int errors = 0, n_checks = 0, cyc, fast, oe_n;

  ebi_bus_if u_ebi_bus_if (.*, .ale_width(ale_w), .code_width(code_w),
    .read_width(read_w), .write_width(write_w), .hold_width(hold_w));
  ebi_mem_model u_ebi_mem_model (.*);

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic do_reset(input logic strap, input logic ext);
    @(negedge sys_clk);
    reset_n = 0;
    width_strap_pin = strap;
    external_code_select_pin = ext;
    repeat (8) @(negedge sys_clk);
    reset_n = 1;
    repeat (5) @(negedge sys_clk);
  endtask : do_reset

  task automatic bus_op(input ebi_kind_t k, input logic [23:0] a,
      input logic [15:0] d, input logic [1:0] be);
    int i = 0;
    req_kind = k;
    req_addr = a;
    req_wdata = d;
    req_byte_en = be;
    req_valid = 1;
    while (req_ready !== 1'b1 && ++i < 40) @(negedge sys_clk);
    @(negedge sys_clk);
    req_valid = 0;
    for (cyc = 1; cyc < 60 && rsp_valid !== 1'b1; cyc++) @(negedge sys_clk);
    `CHK("rsp_valid", 1'b1, rsp_valid)
    oe_n = 0;
    repeat (8) begin
      oe_n += (ext_data_oe === 1'b1);
      @(negedge sys_clk);
    end
  endtask : bus_op

  task automatic t_boot;
    for (int s = 0; s < 2; s++) begin
      do_reset(s[0], !s[0]);
      `CHK("bus_is_16", s[0], bus_is_16)
      `CHK("boot_external", !s[0], boot_external)
      `CHK("config_done", 1'b1, config_done)
    end
    $display("t_boot done");
  endtask : t_boot

  task automatic t_fw;
    do_reset(1'h0, 1'h0);
    for (int v = 1; v >= 0; v--) begin
      fw_width_16 = v[0];
      fw_width_set = 1;
      @(negedge sys_clk);
      fw_width_set = 0;
      @(negedge sys_clk);
      `CHK("fw width", 1'b1, bus_is_16)
      bus_op(EBI_KIND_WRITE, 24'h000005, 16'hA55A, 2'h3);
      `CHK("hold", 2, oe_n)
    end
    $display("t_fw done");
  endtask : t_fw

  task automatic t_lanes;
    bus_op(EBI_KIND_WRITE, 24'h000005, 16'h1234, 2'h2);
    bus_op(EBI_KIND_READ, 24'h000005, 16'h0000, 2'h0);
    `CHK("lane data", 16'h125A, rsp_rdata)
    `CHK("read cycles", 6, cyc)
    `CHK("read oe", 0, oe_n)
    fast = cyc;
    slow = 1;
    bus_op(EBI_KIND_READ, 24'h000005, 16'h0000, 2'h0);
    slow = 0;
    `CHK("wait data", 16'h125A, rsp_rdata)
    `CHK("stretched", 1'b1, cyc > fast + 2)
    bus_op(EBI_KIND_CODE, 24'hAB0033, 16'h0000, 2'h0);
    `CHK("code data", 16'h33C5, rsp_rdata)
    `CHK("address", 24'hAB0033, ext_addr)
    $display("t_lanes done");
  endtask : t_lanes

  task automatic t_8bit;
    addr_lines_cfg = 5'h08;
    do_reset(1'h0, 1'h0);
    bus_op(EBI_KIND_WRITE, 24'h123405, 16'hBEB7, 2'h2);
    `CHK("bus lines", 24'h0000FF, ext_addr_is_bus)
    `CHK("masked", 24'h000005, ext_addr)
    bus_op(EBI_KIND_READ, 24'h000005, 16'h0000, 2'h0);
    `CHK("narrow data", 16'h00B7, rsp_rdata)
    $display("t_8bit done");
  endtask : t_8bit

  task automatic t_timing;
    ale_w = 4'h3;
    read_w = 4'h6;
    bus_op(EBI_KIND_READ, 24'h000005, 16'h0000, 2'h0);
    `CHK("long read", 10, cyc)
    `CHK("long data", 16'h00B7, rsp_rdata)
    ale_w = 4'h0;
    hold_w = 4'h5;
    bus_op(EBI_KIND_WRITE, 24'h000006, 16'h0011, 2'h1);
    `CHK("long hold", 5, oe_n)
    `CHK("short latch", 6, cyc)
    hold_w = 4'h0;
    bus_op(EBI_KIND_WRITE, 24'h000006, 16'h0022, 2'h1);
    `CHK("zero hold", 1, oe_n)
    $display("t_timing done");
  endtask : t_timing

  initial forever #25 sys_clk = ~sys_clk;
  initial begin
    t_boot;
    t_fw;
    t_lanes;
    t_8bit;
    t_timing;
    complete_run;
  end
  initial begin
    #300000;
    errors++;
    complete_run;
  end
endmodule : ebi_bus_if_tb_top

/* File: bench/ebi_mem_model.sv */
/* Far-side memory with address latch and wait maker.
   Assumes active-low strobes and no pull on the data lines. */
`timescale 1ns/1ns
module ebi_mem_model (
  input wire logic sys_clk, slow, address_latch_strobe,
  input wire logic code_fetch_strobe_n, data_read_strobe_n,
  input wire logic low_byte_write_strobe_n, high_byte_write_strobe_n,
  input wire logic [23:0] ext_addr,
  input wire logic [15:0] ext_data_out,
  output logic     [15:0] ext_data_in,
  output logic            wait_pin
);
  logic [15:0] mem [256];
  logic [15:0] junk = 16'h5A5A;
  logic [7:0]  lat;
  int          cnt = 0;
  wire on = !(code_fetch_strobe_n && data_read_strobe_n
    && low_byte_write_strobe_n && high_byte_write_strobe_n);
  always @(negedge address_latch_strobe) lat = ext_addr[7:0];
  always @(posedge sys_clk) junk <= ~junk;
  always @(posedge sys_clk) cnt <= on ? cnt + 1 : 0;
  always @(posedge low_byte_write_strobe_n)
    mem[lat][7:0] = ext_data_out[7:0];
  always @(posedge high_byte_write_strobe_n)
    mem[lat][15:8] = ext_data_out[15:8];
  assign wait_pin = slow && on && cnt < 6;
  // Released lines toggle so a stale value never reads back
  assign ext_data_in = !code_fetch_strobe_n ? {lat, 8'hC5}
    : !data_read_strobe_n ? mem[lat] : junk;
endmodule : ebi_mem_model

/* File: hw/ebi_bus_if.sv */
/*
 * External bus interface: sequences address latch, code fetch, data
 * read and byte-lane write cycles toward external memories.
 * Assumes one core clock, a core-side request port on that clock and
 * pins that are asynchronous and pass two flip-flops before use.
 */
// Operation
// - Drive address, run code/read/write cycles
// - Width at reset from strap pin
// - Firmware may change width before first cycle
// - Eight or sixteen bit data, 24 lines
// - Pulse address latch before each cycle
// - Code strobe only on code reads
// - Read strobe on data reads
// - Eight bit bus: low strobe only
// - Sixteen bit: low strobe for low byte
// - Sixteen bit: high strobe for high byte
// - Wait input stretches any cycle
// - Boot source from external code select pin
// - Configurable count of driven address lines
// - Programmable latch, strobe and hold widths
`timescale 1ns/1ns
`include "ebi_defs.svh"

module ebi_bus_if
  import ebi_pkg::*;
#(
  parameter int ADDR_LINES = `EBI_ADDR_MAX
) (
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire logic                    req_valid,
  input  wire ebi_kind_t               req_kind,
  input  wire logic [ADDR_LINES-1:0]   req_addr,
  input  wire logic [`EBI_DATA_W-1:0]  req_wdata,
  input  wire logic [1:0]              req_byte_en,
  output logic                         req_ready,
  output logic                         rsp_valid,
  output logic [`EBI_DATA_W-1:0]       rsp_rdata,
  input  wire logic                    fw_width_set,
  input  wire logic                    fw_width_16,
  input  wire logic [`EBI_LINES_W-1:0] addr_lines_cfg,
  input  wire logic [`EBI_CNT_W-1:0]   ale_width,
  input  wire logic [`EBI_CNT_W-1:0]   code_width,
  input  wire logic [`EBI_CNT_W-1:0]   read_width,
  input  wire logic [`EBI_CNT_W-1:0]   write_width,
  input  wire logic [`EBI_CNT_W-1:0]   hold_width,
  output logic                         bus_is_16,
  output logic                         boot_external,
  output logic                         config_done,
  input  wire logic                    width_strap_pin,
  input  wire logic                    external_code_select_pin,
  input  wire logic                    wait_pin,
  output logic [ADDR_LINES-1:0]        ext_addr,
  output logic [ADDR_LINES-1:0]        ext_addr_is_bus,
  output logic                         address_latch_strobe,
  output logic                         code_fetch_strobe_n,
  output logic                         data_read_strobe_n,
  output logic                         low_byte_write_strobe_n,
  output logic                         high_byte_write_strobe_n,
  input  wire logic [`EBI_DATA_W-1:0]  ext_data_in,
  output logic [`EBI_DATA_W-1:0]       ext_data_out,
  output logic                         ext_data_oe
);

  if (ADDR_LINES < 1 || ADDR_LINES > `EBI_ADDR_MAX) begin : g_bad_lines
    $error("ADDR_LINES out of range");
  end

  localparam logic [`EBI_CNT_W-1:0] CNT_ONE = `EBI_CNT_W'h1;

  // ***********************************************************
  // Pin synchronisers
  // ***********************************************************
  logic                    strap_s1_reg, strap_s2_reg;
  logic                    sel_s1_reg, sel_s2_reg;
  logic                    wait_s1_reg, wait_s2_reg;
  logic [`EBI_DATA_W-1:0]  din_s1_reg, din_s2_reg;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_s1_reg <= 1'h0;
      strap_s2_reg <= 1'h0;
      sel_s1_reg   <= 1'h0;
      sel_s2_reg   <= 1'h0;
      wait_s1_reg  <= 1'h0;
      wait_s2_reg  <= 1'h0;
      din_s1_reg   <= `EBI_DATA_W'h0;
      din_s2_reg   <= `EBI_DATA_W'h0;
    end else begin
      strap_s1_reg <= width_strap_pin;
      strap_s2_reg <= strap_s1_reg;
      sel_s1_reg   <= external_code_select_pin;
      sel_s2_reg   <= sel_s1_reg;
      wait_s1_reg  <= wait_pin;
      wait_s2_reg  <= wait_s1_reg;
      din_s1_reg   <= ext_data_in;
      din_s2_reg   <= din_s1_reg;
    end
  end

  // ***********************************************************
  // Sequencer
  // ***********************************************************
  ebi_state_t              state_reg, state_next;
  ebi_kind_t               kind_reg;
  logic [`EBI_CNT_W-1:0]   cnt_reg;
  logic [1:0]              be_reg;
  logic [`EBI_DATA_W-1:0]  wdata_reg;
  logic [1:0]              init_cnt_reg;
  logic                    ext_used_reg;
  logic                    accept;
  logic [ADDR_LINES-1:0]   bus_mask;

  assign accept = req_valid && req_ready;

  function automatic logic [`EBI_CNT_W-1:0] at_least_one(
    input logic [`EBI_CNT_W-1:0] w
  );
    at_least_one = (w == `EBI_CNT_W'h0) ? CNT_ONE : w;
  endfunction : at_least_one

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      EBI_ST_IDLE: begin
        if (accept)
          state_next = EBI_ST_ALE;
      end
      EBI_ST_ALE: begin
        if (cnt_reg == CNT_ONE)
          state_next = EBI_ST_STROBE;
      end
      EBI_ST_STROBE: begin
        if (cnt_reg == CNT_ONE && !wait_s2_reg) begin
          if (kind_reg == EBI_KIND_WRITE)
            state_next = EBI_ST_HOLD;
          else
            state_next = EBI_ST_IDLE;
        end
      end
      EBI_ST_HOLD: begin
        if (cnt_reg == CNT_ONE)
          state_next = EBI_ST_IDLE;
      end
      default: state_next = EBI_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      state_reg <= EBI_ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Phase counter, reloaded on every phase change
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= CNT_ONE;
    end else if (state_next != state_reg) begin
      case (state_next)
        EBI_ST_ALE:    cnt_reg <= at_least_one(ale_width);
        EBI_ST_STROBE: begin
          case (kind_reg)
            EBI_KIND_CODE: cnt_reg <= at_least_one(code_width);
            EBI_KIND_READ: cnt_reg <= at_least_one(read_width);
            default:       cnt_reg <= at_least_one(write_width);
          endcase
        end
        EBI_ST_HOLD:   cnt_reg <= at_least_one(hold_width);
        default:       cnt_reg <= CNT_ONE;
      endcase
    end else if (cnt_reg > CNT_ONE) begin
      cnt_reg <= cnt_reg - CNT_ONE;
    end
  end

  // Request capture
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      kind_reg  <= EBI_KIND_CODE;
      be_reg    <= 2'h0;
      wdata_reg <= `EBI_DATA_W'h0;
      ext_addr  <= '0;
    end else begin
      if (accept) begin
        kind_reg  <= req_kind;
        be_reg    <= req_byte_en;
        wdata_reg <= req_wdata;
      end
      ext_addr <= (accept ? req_addr : ext_addr) & bus_mask;
    end
  end

  // ***********************************************************
  // Configuration: strap, boot source, width, address lines
  // ***********************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      init_cnt_reg  <= 2'h0;
      config_done   <= 1'h0;
      bus_is_16     <= `EBI_RST_WIDTH16;
      boot_external <= 1'h0;
      ext_used_reg  <= 1'h0;
    end else begin
      if (!config_done) begin
        if (init_cnt_reg == `EBI_STRAP_WAIT) begin
          config_done   <= 1'h1;
          bus_is_16     <= strap_s2_reg;
          boot_external <= sel_s2_reg;
        end else begin
          init_cnt_reg <= init_cnt_reg + 2'h1;
        end
      end else if (fw_width_set && !ext_used_reg && !accept) begin
        bus_is_16 <= fw_width_16;
      end
      if (accept)
        ext_used_reg <= 1'h1;
    end
  end

  // Same mask for line map and held address, so both move together
  always_comb begin
    bus_mask = '0;
    for (int i = 0; i < ADDR_LINES; i++)
      bus_mask[i] = (i < int'(addr_lines_cfg));
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      ext_addr_is_bus <= '0;
    else
      ext_addr_is_bus <= bus_mask;
  end

  // ***********************************************************
  // Pin strobes and data
  // ***********************************************************
  logic strobe_on, write_on;

  assign strobe_on = (state_next == EBI_ST_STROBE);
  assign write_on  = (kind_reg == EBI_KIND_WRITE);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      address_latch_strobe     <= 1'h0;
      code_fetch_strobe_n      <= `EBI_RST_STROBE_N;
      data_read_strobe_n       <= `EBI_RST_STROBE_N;
      low_byte_write_strobe_n  <= `EBI_RST_STROBE_N;
      high_byte_write_strobe_n <= `EBI_RST_STROBE_N;
    end else begin
      address_latch_strobe <= (state_next == EBI_ST_ALE);
      // Only one class active, chosen by the latched kind
      code_fetch_strobe_n <=
        !(strobe_on && kind_reg == EBI_KIND_CODE);
      data_read_strobe_n <=
        !(strobe_on && kind_reg == EBI_KIND_READ);
      low_byte_write_strobe_n <= !(strobe_on && write_on &&
        (!bus_is_16 || be_reg[0]));
      high_byte_write_strobe_n <= !(strobe_on && write_on &&
        bus_is_16 && be_reg[1]);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_data_out <= `EBI_DATA_W'h0;
      ext_data_oe  <= 1'h0;
    end else begin
      ext_data_oe  <= write_on && (strobe_on ||
                      state_next == EBI_ST_HOLD);
      ext_data_out <= bus_is_16 ? wdata_reg :
                      {8'h00, wdata_reg[7:0]};
    end
  end

  // ***********************************************************
  // Core-side answer
  // ***********************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_ready <= 1'h0;
      rsp_valid <= 1'h0;
      rsp_rdata <= `EBI_DATA_W'h0;
    end else begin
      req_ready <= config_done && !accept &&
                   (state_next == EBI_ST_IDLE);
      rsp_valid <= (state_reg == EBI_ST_STROBE) &&
                   (state_next != EBI_ST_STROBE);
      if (state_reg == EBI_ST_STROBE && state_next != EBI_ST_STROBE &&
          !write_on)
        rsp_rdata <= bus_is_16 ? din_s2_reg :
                     {8'h00, din_s2_reg[7:0]};
    end
  end

endmodule : ebi_bus_if

/* File: hw/ebi_defs.svh */
/*
 * Constants of the external bus interface: line counts, reset values
 * and the strap wait count.
 * Assumes inclusion by bare name from the package and the design.
 */
`ifndef EBI_DEFS_SVH
`define EBI_DEFS_SVH

`define EBI_ADDR_MAX      24
`define EBI_DATA_W        16
`define EBI_CNT_W         4
`define EBI_LINES_W       5
`define EBI_STRAP_WAIT    2'h2
`define EBI_RST_WIDTH16   1'h0
`define EBI_RST_STROBE_N  1'h1

`endif

/* File: hw/ebi_pkg.sv */
/*
 * Types of the external bus interface.
 * Assumes ebi_defs.svh is on the include path.
 */
package ebi_pkg;
  `include "ebi_defs.svh"

  typedef enum logic [1:0] {
    EBI_KIND_CODE  = 2'h0,
    EBI_KIND_READ  = 2'h1,
    EBI_KIND_WRITE = 2'h2
  } ebi_kind_t;

  typedef enum logic [3:0] {
    EBI_ST_IDLE   = 4'h1,
    EBI_ST_ALE    = 4'h2,
    EBI_ST_STROBE = 4'h4,
    EBI_ST_HOLD   = 4'h8
  } ebi_state_t;
endpackage : ebi_pkg
